// File: hw/chan_update_pkg.sv
// shared constants and carriers for the channel update mode registers
package chan_update_pkg;
  localparam int unsigned NUM_CHAN = 16;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CODE_W = 12;
  localparam logic [ADDR_W-1:0] OFFS_UPDATE_MODE = 7'h0A;
  localparam logic [ADDR_W-1:0] OFFS_BCAST_ENABLE = 7'h0B;
  localparam logic [DATA_W-1:0] RST_UPDATE_MODE = 16'h0000;
  localparam logic [DATA_W-1:0] RST_BCAST_ENABLE = 16'hFFFF;
  localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 16'h0000;

  // register access request from the serial interface logic
  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  // buffer write request from the serial interface logic
  typedef struct packed {
    logic valid;
    logic broadcast;
    logic [3:0] chan;
    logic [CODE_W-1:0] code;
  } buf_wr_s;
endpackage : chan_update_pkg

// File: hw/channel_update_mode_regs.sv
// update-mode and broadcast-enable registers with per-channel code staging
`timescale 1ns/1ns
`default_nettype none

module channel_update_mode_regs #(
  parameter int unsigned NUM_CHAN = chan_update_pkg::NUM_CHAN,
  parameter int unsigned CODE_W = chan_update_pkg::CODE_W
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // register access
  input wire chan_update_pkg::reg_req_s i_reg_req,
  output logic [chan_update_pkg::DATA_W-1:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // buffer writes and trigger
  input wire chan_update_pkg::buf_wr_s i_buf_wr,
  input wire logic i_trigger,
  // channel state
  output logic [NUM_CHAN*CODE_W-1:0] o_active_codes,
  output logic [NUM_CHAN-1:0] o_update_mode,
  output logic [NUM_CHAN-1:0] o_bcast_enable
);

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [NUM_CHAN-1:0] update_mode_reg;
  logic [NUM_CHAN-1:0] bcast_enable_reg;
  logic wr_mode;
  logic wr_bcast;

  assign wr_mode = i_reg_req.valid && i_reg_req.write &&
    (i_reg_req.addr == chan_update_pkg::OFFS_UPDATE_MODE);
  assign wr_bcast = i_reg_req.valid && i_reg_req.write &&
    (i_reg_req.addr == chan_update_pkg::OFFS_BCAST_ENABLE);

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      update_mode_reg <= chan_update_pkg::RST_UPDATE_MODE[NUM_CHAN-1:0];
    else if (wr_mode)
      update_mode_reg <= i_reg_req.wdata[NUM_CHAN-1:0];
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      bcast_enable_reg <= chan_update_pkg::RST_BCAST_ENABLE[NUM_CHAN-1:0];
    else if (wr_bcast)
      bcast_enable_reg <= i_reg_req.wdata[NUM_CHAN-1:0];
  end

  // reads answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_reg_rdata <= chan_update_pkg::RDATA_UNMAPPED;
      o_reg_rvalid <= 1'b0;
    end
    else
    begin
      o_reg_rvalid <= i_reg_req.valid && !i_reg_req.write;
      if (i_reg_req.valid && !i_reg_req.write)
      begin
        if (i_reg_req.addr == chan_update_pkg::OFFS_UPDATE_MODE)
          o_reg_rdata <= chan_update_pkg::DATA_W'(update_mode_reg);
        else if (i_reg_req.addr == chan_update_pkg::OFFS_BCAST_ENABLE)
          o_reg_rdata <= chan_update_pkg::DATA_W'(bcast_enable_reg);
        else
          o_reg_rdata <= chan_update_pkg::RDATA_UNMAPPED;
      end
    end
  end

  assign o_update_mode = update_mode_reg;
  assign o_bcast_enable = bcast_enable_reg;

  // ---------------------------------------------------------------
  // buffer and active codes
  // ---------------------------------------------------------------
  logic [CODE_W-1:0] buf_reg [NUM_CHAN];
  logic [CODE_W-1:0] active_reg [NUM_CHAN];
  logic [NUM_CHAN-1:0] buf_hit;

  always_comb
  begin
    for (int n = 0; n < NUM_CHAN; n++)
      buf_hit[n] = i_buf_wr.valid && (i_buf_wr.broadcast ?
        bcast_enable_reg[n] : (32'(i_buf_wr.chan) == n));
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int n = 0; n < NUM_CHAN; n++)
        buf_reg[n] <= '0;
    end
    else
    begin
      for (int n = 0; n < NUM_CHAN; n++)
        if (buf_hit[n])
          buf_reg[n] <= i_buf_wr.code;
    end
  end

  // a write in the trigger cycle stays buffered for the next trigger
  // per-channel mode bit selects path
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int n = 0; n < NUM_CHAN; n++)
        active_reg[n] <= '0;
    end
    else
    begin
      for (int n = 0; n < NUM_CHAN; n++)
      begin
        if (!update_mode_reg[n] && buf_hit[n])
          active_reg[n] <= i_buf_wr.code;
        else if (update_mode_reg[n] && i_trigger)
          active_reg[n] <= buf_reg[n];
      end
    end
  end

  // flat view: channel n occupies slice n of the code bus
  always_comb
  begin
    for (int n = 0; n < NUM_CHAN; n++)
      o_active_codes[n*CODE_W +: CODE_W] = active_reg[n];
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_mode_reset_zero: assert property (
    @(posedge i_clock) $rose(i_rst_n) |-> update_mode_reg == '0)
    else $error("mode register not zero after reset");

  a_mode_write_store: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    wr_mode |=> update_mode_reg == $past(i_reg_req.wdata[NUM_CHAN-1:0]))
    else $error("mode write not stored");

  a_bcast_write_store: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    wr_bcast |=> bcast_enable_reg == $past(i_reg_req.wdata[NUM_CHAN-1:0]))
    else $error("broadcast write not stored");

  a_bcast_reset_ones: assert property (
    @(posedge i_clock) $rose(i_rst_n) |-> &bcast_enable_reg)
    else $error("broadcast register not ones after reset");

  a_direct_follow: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_buf_wr.valid && !i_buf_wr.broadcast &&
     !update_mode_reg[i_buf_wr.chan])
    |=> active_reg[$past(i_buf_wr.chan)] == $past(i_buf_wr.code))
    else $error("direct channel did not follow buffer");

  a_mode_hold_idle: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    !wr_mode |=> $stable(update_mode_reg))
    else $error("mode register changed without a write");

  a_write_no_answer: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_reg_req.valid && i_reg_req.write) |=> !o_reg_rvalid)
    else $error("write produced a read answer");

  // every channel checked, not only one the scenarios may never touch
  for (genvar n = 0; n < NUM_CHAN; n++)
  begin : g_chan_check
    a_held_no_trigger: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (update_mode_reg[n] && !i_trigger)
      |=> $stable(active_reg[n]))
      else $error("triggered channel changed without trigger");

    a_trigger_transfer: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (update_mode_reg[n] && i_trigger)
      |=> active_reg[n] == $past(buf_reg[n]))
      else $error("trigger did not transfer buffer");

    a_bcast_ignored: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_buf_wr.valid && i_buf_wr.broadcast && !bcast_enable_reg[n])
      |=> $stable(buf_reg[n]))
      else $error("disabled channel took broadcast");

    a_bcast_accepted: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_buf_wr.valid && i_buf_wr.broadcast && bcast_enable_reg[n])
      |=> buf_reg[n] == $past(i_buf_wr.code))
      else $error("enabled channel missed broadcast");

    a_mode_bit_select: assert property (
      @(posedge i_clock) disable iff (!i_rst_n)
      (buf_hit[n] && !update_mode_reg[n])
      |=> active_reg[n] == $past(i_buf_wr.code))
      else $error("channel ignored its own mode bit");
  end

  a_read_answer: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_reg_req.valid && !i_reg_req.write &&
     i_reg_req.addr == chan_update_pkg::OFFS_UPDATE_MODE)
    |=> o_reg_rvalid && o_reg_rdata == $past(update_mode_reg))
    else $error("mode readback wrong");

endmodule : channel_update_mode_regs

`default_nettype wire

// File: tb/channel_update_mode_regs_test.sv
// self-checking bench for the channel update mode registers
`timescale 1ns/1ns
`default_nettype none

module channel_update_mode_regs_test;
  logic i_clock;
  logic i_rst_n;
  chan_update_pkg::reg_req_s i_reg_req;
  chan_update_pkg::buf_wr_s i_buf_wr;
  logic i_trigger;
  logic [15:0] o_reg_rdata;
  logic o_reg_rvalid;
  logic [191:0] o_active_codes;
  logic [15:0] o_update_mode;
  logic [15:0] o_bcast_enable;
  int miscompares;
  int samples_checked;

  channel_update_mode_regs DUT (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .i_buf_wr(i_buf_wr),
    .i_trigger(i_trigger), .o_active_codes(o_active_codes),
    .o_update_mode(o_update_mode), .o_bcast_enable(o_bcast_enable));

  initial
  begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic chk(input logic [191:0] seen, input logic [191:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, want);
    end
  endtask : chk

  // request held for exactly one sampling edge
  task automatic r(input logic w, input logic [6:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_reg_req <= '{1'b1, w, a, d};
    @(posedge i_clock);
    i_reg_req <= '0;
    #1;
  endtask : r

  task automatic b(input logic bc, input logic [3:0] ch, input logic [11:0] c);
    @(posedge i_clock);
    i_buf_wr <= '{1'b1, bc, ch, c};
    @(posedge i_clock);
    i_buf_wr <= '0;
    #1;
  endtask : b

  task automatic trig();
    @(posedge i_clock);
    i_trigger <= 1'b1;
    @(posedge i_clock);
    i_trigger <= 1'b0;
    #1;
  endtask : trig

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic test_reset();
    chk(o_update_mode, chan_update_pkg::RST_UPDATE_MODE);
    chk(o_bcast_enable, chan_update_pkg::RST_BCAST_ENABLE);
    chk(o_active_codes, '0);
    r(1'b0, chan_update_pkg::OFFS_UPDATE_MODE, 16'h0000);
    chk({o_reg_rvalid, o_reg_rdata}, 17'h10000);
    r(1'b0, chan_update_pkg::OFFS_BCAST_ENABLE, 16'h0000);
    chk({o_reg_rvalid, o_reg_rdata}, 17'h1FFFF);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_regs();
    r(1'b1, chan_update_pkg::OFFS_UPDATE_MODE, 16'h8008);
    chk(o_reg_rvalid, 1'b0);
    chk(o_update_mode, 16'h8008);
    r(1'b1, chan_update_pkg::OFFS_BCAST_ENABLE, 16'h00F0);
    chk(o_bcast_enable, 16'h00F0);
    r(1'b1, 7'h0C, 16'h1234);
    r(1'b0, chan_update_pkg::OFFS_UPDATE_MODE, 16'h0000);
    chk({o_reg_rvalid, o_reg_rdata}, 17'h18008);
    r(1'b0, 7'h0C, 16'h0000);
    chk(o_reg_rdata, chan_update_pkg::RDATA_UNMAPPED);
    chk(o_bcast_enable, 16'h00F0);
    $display("test_regs done");
  endtask : test_regs

  task automatic test_modes();
    b(1'b0, 4'h0, 12'h123);
    chk(o_active_codes[11:0], 12'h123);
    b(1'b0, 4'h3, 12'hABC);
    chk(o_active_codes[47:36], 12'h000);
    b(1'b0, 4'h3, 12'hABD);
    chk(o_active_codes[47:36], 12'h000);
    trig();
    chk(o_active_codes[47:36], 12'hABD);
    b(1'b0, 4'hF, 12'h0F1);
    chk(o_active_codes[191:180], 12'h000);
    trig();
    chk(o_active_codes[191:180], 12'h0F1);
    $display("test_modes done");
  endtask : test_modes

  task automatic test_bcast();
    b(1'b1, 4'h0, 12'h5A5);
    chk(o_active_codes[95:48], {4{12'h5A5}});
    chk(o_active_codes[11:0], 12'h123);
    chk(o_active_codes[107:96], 12'h000);
    r(1'b1, chan_update_pkg::OFFS_BCAST_ENABLE, 16'h8000);
    b(1'b1, 4'h4, 12'h3C3);
    chk(o_active_codes[59:48], 12'h5A5);
    trig();
    chk(o_active_codes[191:180], 12'h3C3);
    $display("test_bcast done");
  endtask : test_bcast

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  // whole run is a few dozen cycles
  initial
  begin
    #20000;
    miscompares++;
    summarize();
  end

  initial
  begin
    i_rst_n = 1'b0;
    i_reg_req = '0;
    i_buf_wr = '0;
    i_trigger = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    repeat (4) @(posedge i_clock);
    i_rst_n <= 1'b1;
    #1;
    test_reset();
    test_regs();
    test_modes();
    test_bcast();
    summarize();
  end
endmodule : channel_update_mode_regs_test

`default_nettype wire
